/* File: host_bus_model.sv */
// host model: drives chip select, strobes and data of the parallel bus
// assumes its task is called at a falling edge of sys_clk_i
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
   input  wire logic        sys_clk_i,
   output logic             chip_select_n_o,
   output logic             read_strobe_n_o,
   output logic             write_strobe_n_o,
   output logic [15:0]      bus_data_o
);
   // ====================
   // strobe access
   logic gate_strobes = 1'h0; // block strobes while deselected
   // bus idle at time zero
   initial begin
      {chip_select_n_o, read_strobe_n_o, write_strobe_n_o} = 3'h7;
      bus_data_o = 16'h0000;
   end
   // one access, changes at falling edges, strobe held two cycles
   task automatic access(input logic wr, input logic sel,
                         input logic [15:0] d);
      logic pass;
      pass = sel | ~gate_strobes;
      chip_select_n_o = ~sel;
      bus_data_o = d;
      write_strobe_n_o = ~(wr & pass);
      read_strobe_n_o = ~(~wr & pass);
      repeat (2) @(negedge sys_clk_i);
      {read_strobe_n_o, write_strobe_n_o} = 2'h3;
      @(negedge sys_clk_i);
      chip_select_n_o = 1'h1;
      bus_data_o = ~d; // released bus shows no stale value
      @(negedge sys_clk_i);
   endtask
endmodule // host_bus_model
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the reset, timer and flag control block
// assumes the design and host_bus_model are compiled first
`include "tdc_ctrl_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // ====================
   // signals
   logic sys_clk_i, rst_b_i, power_up_reset_n_i, sw_full_reset_i;
   logic sw_partial_reset_i, quiet_mode_i, full_reset_on_trigger_pin_i;
   logic full_reset_on_drive_pin_i, partial_reset_on_trigger_pin_i;
   logic partial_reset_on_drive_pin_i, drive_force_unused_i, trigger_pin_i;
   logic bus_drive_force_n_i, timer_launch_on_start_i;
   logic ref_tick_i = 1'h0; // driven by the tick process only
   logic timer_launch_on_stop_i, start_event_i, stop_event_i;
   logic timer_irq_enable_i, pll_unlocked_i, hit_fifos_empty_i;
   logic test_select_i, half_mode_i, chip_select_n_i, read_strobe_n_i;
   logic write_strobe_n_i, full_reset_o, partial_reset_o, clear_if_fifos_o;
   logic inputs_open_o, timer_running_o, interrupt_flag_o, error_flag_o;
   logic half_pointer_o, bus_word_valid_o;
   logic [`TIMER_W-1:0]   timer_period_i;
   logic [`IRQ_SRC_W-2:0] irq_mask_i;
   logic [`ERR_SRC_W-1:0] err_mask_i;
   logic [`HIT_FIFOS-1:0] hit_fifo_full_i;
   logic [1:0]            if_fifo_full_i;
   logic [2:0]            meas_in_i, test_in_i, core_in_o;
   logic [`HALF_W-1:0]    bus_data_i;
   logic [`WORD_W-1:0]    bus_word_o, word_seen;
   int                    mismatches, tests_run, n, valid_cnt, base;
   // causes {swf,swp,quiet,fte,fde,pte,pde,unused,trig,drive_n}
   logic [9:0] cfg [9] = '{10'h201, 10'h043, 10'h0A4, 10'h101, 10'h013,
                           10'h08C, 10'h0C3, 10'h0A0, 10'h024};
   logic [1:0] expv [9] = '{2'h2, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1, 2'h0,
                            2'h0, 2'h0};
   tdc_reset_timer_flag_control u_dut (.*);
   host_bus_model u_host (.sys_clk_i(sys_clk_i),
      .chip_select_n_o(chip_select_n_i), .read_strobe_n_o(read_strobe_n_i),
      .write_strobe_n_o(write_strobe_n_i), .bus_data_o(bus_data_i));
   // clock, reference tick every second cycle, word monitor
   initial begin
      sys_clk_i = 1'h0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end
   always @(negedge sys_clk_i) begin
      ref_tick_i <= ~ref_tick_i;
      if (bus_word_valid_o === 1'h1) begin
         word_seen = bus_word_o;
         valid_cnt++;
      end
   end
   // ====================
   // tasks
   task automatic check(input string nm, input logic [27:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic settle;
      repeat (2) @(negedge sys_clk_i);
   endtask
   task automatic set_cfg(input logic [9:0] c);
      {sw_full_reset_i, sw_partial_reset_i, quiet_mode_i,
       full_reset_on_trigger_pin_i, full_reset_on_drive_pin_i,
       partial_reset_on_trigger_pin_i, partial_reset_on_drive_pin_i,
       drive_force_unused_i, trigger_pin_i, bus_drive_force_n_i} = c;
   endtask
   // wait for reset end, then count closed cycles; launch tried meanwhile
   task automatic recover(input int cyc);
      int k;
      k = 0;
      while ((full_reset_o | partial_reset_o) !== 1'h0 && k < 10) begin
         @(negedge sys_clk_i);
         k++;
      end
      start_event_i = 1'h1;
      k = 0;
      while (inputs_open_o !== 1'h1 && k < 10) begin
         @(negedge sys_clk_i);
         start_event_i = 1'h0;
         k++;
      end
      start_event_i = 1'h0;
      check("recovery", k >= cyc && k <= cyc + 2, 1'h1);
      check("launch_refused", timer_running_o, 1'h0);
   endtask
   task automatic launch(input logic w, input logic run, input int per);
      timer_period_i = per[12:0];
      {stop_event_i, start_event_i} = w ? 2'h2 : 2'h1;
      @(negedge sys_clk_i);
      {stop_event_i, start_event_i} = 2'h0;
      @(negedge sys_clk_i);
      check("timer_running", timer_running_o, run);
      n = 0;
      while (timer_running_o === 1'h1 && n < 20000) begin
         @(negedge sys_clk_i);
         n++;
      end
      settle;
      if (run) begin
         check("timer_span", n >= 2*per-4 && n <= 2*per+4, 1'h1);
         check("timer_irq", interrupt_flag_o, timer_irq_enable_i);
      end
   endtask
   task automatic realign;
      half_mode_i = 1'h0;
      u_host.access(1'h1, 1'h1, 16'h0000);
      u_host.access(1'h1, 1'h1, 16'h0000);
      half_mode_i = 1'h1;
      settle;
   endtask
   task automatic close_out;
      if (mismatches == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // watchdog well beyond the longest timer run
   initial begin
      repeat (40000) @(posedge sys_clk_i);
      mismatches++;
      close_out;
   end
   // ====================
   // main sequence
   initial begin
      {rst_b_i, power_up_reset_n_i} = 2'h1;
      set_cfg(10'h001);
      {timer_launch_on_start_i, timer_launch_on_stop_i} = 2'h2;
      {start_event_i, stop_event_i, timer_irq_enable_i} = 3'h1;
      {pll_unlocked_i, hit_fifos_empty_i, if_fifo_full_i} = 4'h0;
      {test_select_i, half_mode_i, hit_fifo_full_i} = 10'h000;
      {timer_period_i, irq_mask_i, err_mask_i} = 36'h000000003 << 23;
      {meas_in_i, test_in_i} = 6'h2A;
      {mismatches, tests_run, valid_cnt} = 96'h0;
      repeat (20) @(negedge sys_clk_i);
      check("rst_full", {full_reset_o, inputs_open_o}, 2'h2);
      rst_b_i = 1'h1;
      recover(`FULL_RECOVER_CYC);
      power_up_reset_n_i = 1'h0;
      settle;
      check("pu_full", {full_reset_o, clear_if_fifos_o}, 2'h3);
      power_up_reset_n_i = 1'h1;
      recover(`FULL_RECOVER_CYC);
      for (int i = 0; i < 12; i++) begin
         {hit_fifos_empty_i, pll_unlocked_i, if_fifo_full_i,
          hit_fifo_full_i} = 12'h001 << i;
         {irq_mask_i, err_mask_i} = {12'h001 << i, 11'h7FF};
         settle;
         check("irq_one", interrupt_flag_o, 1'h1);
         check("err_any", error_flag_o, i < 11);
         {irq_mask_i, err_mask_i} = {~(12'h001 << i), ~(11'h001 << i)};
         settle;
         check("irq_off", {interrupt_flag_o, error_flag_o}, 2'h0);
      end
      {hit_fifos_empty_i, pll_unlocked_i, if_fifo_full_i} = 4'h0;
      hit_fifo_full_i = 8'h00;
      settle;
      check("core_meas", core_in_o, 3'h5);
      test_select_i = 1'h1;
      settle;
      check("core_test", core_in_o, 3'h2);
      for (int i = 0; i < 9; i++) begin
         set_cfg(cfg[i]);
         settle;
         check("reset_kind", {full_reset_o, partial_reset_o}, expv[i]);
         check("fifo_clear", clear_if_fifos_o, expv[i][1]);
         set_cfg(10'h001);
         if (expv[i] != 2'h0) begin
            recover(expv[i][1] ? `FULL_RECOVER_CYC : `PART_RECOVER_CYC);
         end else begin
            settle;
         end
      end
      for (int m = 1; m < 4; m++) begin
         for (int w = 0; w < 2; w++) begin
            {timer_launch_on_stop_i, timer_launch_on_start_i} = m[1:0];
            timer_irq_enable_i = !(m == 3 && w == 1);
            launch(w[0], w ? m[1] : m[0], 3);
         end
      end
      timer_irq_enable_i = 1'h1;
      launch(1'h0, 1'h1, 8191);
      power_up_reset_n_i = 1'h0;
      settle;
      check("pu_flag", interrupt_flag_o, 1'h0);
      power_up_reset_n_i = 1'h1;
      recover(`FULL_RECOVER_CYC);
      realign;
      check("ptr_align", half_pointer_o, 1'h0);
      base = valid_cnt;
      u_host.access(1'h1, 1'h1, 16'hABCD);
      check("ptr_low", half_pointer_o, 1'h1);
      u_host.access(1'h1, 1'h1, 16'h1234);
      check("word_cnt", valid_cnt - base, 28'h1);
      check("word", word_seen, {12'h234, 16'hABCD});
      check("ptr_back", half_pointer_o, 1'h0);
      u_host.access(1'h0, 1'h0, 16'h5555);
      check("ptr_desel", half_pointer_o, 1'h1);
      realign;
      u_host.gate_strobes = 1'h1;
      u_host.access(1'h0, 1'h0, 16'h5555);
      check("ptr_gated", half_pointer_o, 1'h0);
      close_out;
   end
endmodule // tb_top
`default_nettype wire

/* File: tdc_ctrl_map.svh */
// constants for the converter reset, timer and flag control block
// assumes a 20 MHz system clock; included by the control module and the bench
`ifndef TDC_CTRL_MAP_SVH
`define TDC_CTRL_MAP_SVH
`define CLK_PERIOD_NS      50
`define FULL_RECOVER_NS    40
`define PART_RECOVER_NS    75
// least times round up to whole cycles
`define FULL_RECOVER_CYC   ((`FULL_RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PART_RECOVER_CYC   ((`PART_RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMER_MAX          13'h1FFF
`define TIMER_W            13
`define HIT_FIFOS          8
`define IRQ_SRC_W          13
`define ERR_SRC_W          11
`define HALF_W             16
`define WORD_W             28
`endif

/* File: tdc_ctrl_pkg.sv */
// types for the converter reset, timer and flag control block
// assumes nothing beyond a SystemVerilog compiler
package tdc_ctrl_pkg;
   typedef enum logic [1:0] {RST_NONE, RST_PART, RST_FULL} reset_kind_e;
   typedef enum logic [1:0] {GATE_OPEN, GATE_HOLD} gate_state_e;
endpackage

/* File: tdc_reset_timer_flag_control.sv */
// reset sequencing, interval timer, interrupt and error flags, test input
// selection and 16-bit half-word latch pointer for the converter
// assumes all inputs synchronous to sys_clk_i, strobes sampled as levels
// Functional notes
// - power-up reset pin low clears all state, configuration included
// - software full-reset command clears all but configuration; here it keeps half_pointer_o
// - outside quiet mode, enabled trigger pin high does a full reset
// - in quiet mode, enabled drive pin low does a full reset
// - software partial reset clears all but configuration and interface fifos; here it keeps half_pointer_o
// - outside quiet mode, enabled trigger pin high does a partial reset
// - in quiet mode, enabled drive pin low does a partial reset
// - after power-up or full reset, start and stop ignored for 40 ns
// - after partial reset, start and stop ignored for 75 ns
// - timer period is reference-clock count, at most 8191
// - timer launches on start, stop or either per two enable bits
// - timer expiry raises interrupt when its enable is set
// - interrupt is OR of unmasked sources
// - error is OR of unmasked full and pll sources
// - test select routes three test inputs to the measuring circuit
// - 16-bit mode pairs two half-word latches into 28 bits
// - latch pointer toggles on every strobe, even with chip select high
`include "tdc_ctrl_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tdc_reset_timer_flag_control (
   input  wire logic                    sys_clk_i,
   input  wire logic                    rst_b_i,
   input  wire logic                    power_up_reset_n_i,
   input  wire logic                    sw_full_reset_i,
   input  wire logic                    sw_partial_reset_i,
   input  wire logic                    quiet_mode_i,
   input  wire logic                    full_reset_on_trigger_pin_i,
   input  wire logic                    full_reset_on_drive_pin_i,
   input  wire logic                    partial_reset_on_trigger_pin_i,
   input  wire logic                    partial_reset_on_drive_pin_i,
   input  wire logic                    drive_force_unused_i,
   input  wire logic                    trigger_pin_i,
   input  wire logic                    bus_drive_force_n_i,
   input  wire logic [`TIMER_W-1:0]     timer_period_i,
   input  wire logic                    timer_launch_on_start_i,
   input  wire logic                    timer_launch_on_stop_i,
   input  wire logic                    ref_tick_i,
   input  wire logic                    start_event_i,
   input  wire logic                    stop_event_i,
   input  wire logic                    timer_irq_enable_i,
   input  wire logic [`IRQ_SRC_W-2:0]   irq_mask_i,
   input  wire logic [`ERR_SRC_W-1:0]   err_mask_i,
   input  wire logic [`HIT_FIFOS-1:0]   hit_fifo_full_i,
   input  wire logic [1:0]              if_fifo_full_i,
   input  wire logic                    pll_unlocked_i,
   input  wire logic                    hit_fifos_empty_i,
   input  wire logic                    test_select_i,
   input  wire logic [2:0]              meas_in_i,
   input  wire logic [2:0]              test_in_i,
   input  wire logic                    half_mode_i,
   input  wire logic                    chip_select_n_i,
   input  wire logic                    read_strobe_n_i,
   input  wire logic                    write_strobe_n_i,
   input  wire logic [`HALF_W-1:0]      bus_data_i,
   output logic                         full_reset_o,
   output logic                         partial_reset_o,
   output logic                         clear_if_fifos_o,
   output logic                         inputs_open_o,
   output logic                         timer_running_o,
   output logic                         interrupt_flag_o,
   output logic                         error_flag_o,
   output logic [2:0]                   core_in_o,
   output logic                         half_pointer_o,
   output logic [`WORD_W-1:0]           bus_word_o,
   output logic                         bus_word_valid_o
);
   // ==========================================================
   // reset request decode
   // ==========================================================
   tdc_ctrl_pkg::reset_kind_e kind_d;
   logic drive_pin_low;
   assign drive_pin_low = quiet_mode_i & drive_force_unused_i
                        & ~bus_drive_force_n_i;
   always_comb begin
      kind_d = tdc_ctrl_pkg::RST_NONE;
      if (sw_full_reset_i
          | (~quiet_mode_i & full_reset_on_trigger_pin_i & trigger_pin_i)
          | (drive_pin_low & full_reset_on_drive_pin_i)) begin
         kind_d = tdc_ctrl_pkg::RST_FULL;
      end else if (sw_partial_reset_i
          | (~quiet_mode_i & partial_reset_on_trigger_pin_i
             & trigger_pin_i)
          | (drive_pin_low & partial_reset_on_drive_pin_i)) begin
         kind_d = tdc_ctrl_pkg::RST_PART;
      end
   end

   // combined local reset: power-up pin acts as a synchronous reset too
   logic pu_q;
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) pu_q <= 1'b1;
      else          pu_q <= ~power_up_reset_n_i;
   end

   // registered reset pulses toward the core
   logic full_now;
   assign full_now = ~power_up_reset_n_i | (kind_d == tdc_ctrl_pkg::RST_FULL);
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         full_reset_o     <= 1'b1;
         partial_reset_o  <= 1'b0;
         clear_if_fifos_o <= 1'b1;
      end else begin
         full_reset_o     <= full_now;
         partial_reset_o  <= kind_d == tdc_ctrl_pkg::RST_PART;
         clear_if_fifos_o <= full_now;
      end
   end

   // ==========================================================
   // input recovery gate
   // ==========================================================
   tdc_ctrl_pkg::gate_state_e gate_q;
   logic [1:0] gate_cnt_q;
   logic       any_reset;
   assign any_reset = ~power_up_reset_n_i | (kind_d != tdc_ctrl_pkg::RST_NONE);
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         gate_q     <= tdc_ctrl_pkg::GATE_HOLD;
         gate_cnt_q <= 2'(`FULL_RECOVER_CYC);
      end else if (any_reset) begin
         gate_q     <= tdc_ctrl_pkg::GATE_HOLD;
         gate_cnt_q <= (kind_d == tdc_ctrl_pkg::RST_PART && power_up_reset_n_i)
                       ? 2'(`PART_RECOVER_CYC)
                       : 2'(`FULL_RECOVER_CYC);
      end else begin
         unique case (gate_q)
            tdc_ctrl_pkg::GATE_OPEN: gate_q <= tdc_ctrl_pkg::GATE_OPEN;
            tdc_ctrl_pkg::GATE_HOLD: begin
               if (gate_cnt_q <= 2'h1) gate_q <= tdc_ctrl_pkg::GATE_OPEN;
               gate_cnt_q <= gate_cnt_q - 2'h1;
            end
         endcase
      end
   end
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) inputs_open_o <= 1'b0;
      else inputs_open_o <= ~any_reset
                            & (gate_q == tdc_ctrl_pkg::GATE_OPEN);
   end

   // ==========================================================
   // interval timer
   // ==========================================================
   logic [`TIMER_W-1:0] tmr_cnt_q;
   logic                tmr_done_q;
   logic                launch;
   logic                expire_now;
   // expiry in this cycle, kept even when a relaunch lands on it
   assign expire_now = timer_running_o & ref_tick_i
                     & (tmr_cnt_q <= `TIMER_W'h1);
   assign launch = inputs_open_o & ((timer_launch_on_start_i & start_event_i)
                 | (timer_launch_on_stop_i & stop_event_i));
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tmr_cnt_q       <= '0;
         timer_running_o <= 1'b0;
         tmr_done_q      <= 1'b0;
      end else if (pu_q || any_reset) begin
         tmr_cnt_q       <= '0;
         timer_running_o <= 1'b0;
         tmr_done_q      <= 1'b0;
      end else if (launch) begin
         tmr_cnt_q       <= timer_period_i;
         timer_running_o <= 1'b1;
         tmr_done_q      <= expire_now; // set wins over relaunch clear
      end else if (timer_running_o && ref_tick_i) begin
         if (tmr_cnt_q <= `TIMER_W'h1) begin
            timer_running_o <= 1'b0;
            tmr_done_q      <= 1'b1; // expiry stays until reset or relaunch
         end
         tmr_cnt_q <= tmr_cnt_q - `TIMER_W'h1;
      end
   end

   // ==========================================================
   // interrupt and error flags
   // ==========================================================
   logic [`IRQ_SRC_W-1:0] irq_src;
   logic [`ERR_SRC_W-1:0] err_src;
   assign irq_src = {tmr_done_q, hit_fifos_empty_i, pll_unlocked_i,
                     if_fifo_full_i, hit_fifo_full_i};
   assign err_src = {pll_unlocked_i, if_fifo_full_i, hit_fifo_full_i};
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         interrupt_flag_o <= 1'b0;
         error_flag_o     <= 1'b0;
      end else if (pu_q) begin
         interrupt_flag_o <= 1'b0;
         error_flag_o     <= 1'b0;
      end else begin
         interrupt_flag_o <= |(irq_src & {timer_irq_enable_i, irq_mask_i});
         error_flag_o     <= |(err_src & err_mask_i);
      end
   end

   // ==========================================================
   // test input multiplexer
   // ==========================================================
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) core_in_o <= 3'h0;
      else core_in_o <= test_select_i ? test_in_i : meas_in_i;
   end

   // ==========================================================
   // 16-bit half-word latches
   // ==========================================================
   logic strobe_q;
   logic strobe_rise;
   logic [`HALF_W-1:0] low_half_q;
   assign strobe_rise = ~(read_strobe_n_i & write_strobe_n_i) & ~strobe_q;
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) strobe_q <= 1'b0;
      else strobe_q <= ~(read_strobe_n_i & write_strobe_n_i);
   end
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         half_pointer_o   <= 1'b0;
         low_half_q       <= '0;
         bus_word_o       <= '0;
         bus_word_valid_o <= 1'b0;
      end else begin
         bus_word_valid_o <= 1'b0;
         if (pu_q || !half_mode_i) begin
            half_pointer_o <= 1'b0;
         end else if (strobe_rise) begin
            half_pointer_o <= ~half_pointer_o; // defect kept: no select gate
            if (!chip_select_n_i && !write_strobe_n_i) begin
               if (!half_pointer_o) begin
                  low_half_q <= bus_data_i;
               end else begin
                  bus_word_o       <= {bus_data_i[`WORD_W-`HALF_W-1:0], low_half_q};
                  bus_word_valid_o <= 1'b1;
               end
            end
         end
      end
   end

   // ==========================================================
   // checks
   // ==========================================================
   full_gate_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      full_reset_o |-> !inputs_open_o) else $error("inputs open during full reset");
   part_gate_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      $fell(partial_reset_o) && !any_reset |-> !inputs_open_o ##1 !inputs_open_o)
      else $error("partial recovery too short");
   timer_load_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      launch && !pu_q && !any_reset |=> timer_running_o && tmr_cnt_q == $past(timer_period_i))
      else $error("timer not loaded");
   timer_launch_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      !timer_running_o && !launch ##1 !any_reset |-> !timer_running_o)
      else $error("timer started without launch");
   irq_timer_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i || pu_q)
      tmr_done_q && timer_irq_enable_i |=> interrupt_flag_o)
      else $error("timer expiry missed interrupt");
   irq_mask_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (irq_src & {timer_irq_enable_i, irq_mask_i}) == '0 |=> !interrupt_flag_o)
      else $error("masked interrupt raised");
   err_flag_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i || pu_q)
      (|(err_src & err_mask_i)) |=> error_flag_o) else $error("error flag missing");
   test_mux_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      test_select_i |=> core_in_o == $past(test_in_i)) else $error("test mux wrong");
   pointer_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      half_mode_i && !pu_q && strobe_rise |=> half_pointer_o != $past(half_pointer_o))
      else $error("pointer did not toggle");
   trig_full_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      !quiet_mode_i && full_reset_on_trigger_pin_i && trigger_pin_i |=> full_reset_o)
      else $error("trigger pin full reset missed");

   // ==========================================================
   // checks on reset causes, sources and word pairing
   // ==========================================================
   pu_reset_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      !power_up_reset_n_i |=> full_reset_o && clear_if_fifos_o)
      else $error("power-up reset not passed on");
   sw_full_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      sw_full_reset_i |=> full_reset_o && clear_if_fifos_o)
      else $error("software full reset missed");
   drive_full_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      quiet_mode_i && drive_force_unused_i && !bus_drive_force_n_i
      && full_reset_on_drive_pin_i |=> full_reset_o)
      else $error("drive pin full reset missed");
   part_keep_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      partial_reset_o && !full_reset_o |-> !clear_if_fifos_o)
      else $error("partial reset cleared interface fifos");
   trig_part_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      !quiet_mode_i && partial_reset_on_trigger_pin_i && trigger_pin_i
      |=> partial_reset_o || full_reset_o)
      else $error("trigger pin partial reset missed");
   drive_part_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      quiet_mode_i && drive_force_unused_i && !bus_drive_force_n_i
      && partial_reset_on_drive_pin_i |=> partial_reset_o || full_reset_o)
      else $error("drive pin partial reset missed");
   launch_gate_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      !inputs_open_o && !timer_running_o |=> !timer_running_o)
      else $error("timer launched while inputs closed");
   irq_src_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i || pu_q)
      (hit_fifos_empty_i && irq_mask_i[11]) || (|(if_fifo_full_i
      & irq_mask_i[9:8])) || (|(hit_fifo_full_i & irq_mask_i[7:0]))
      |=> interrupt_flag_o) else $error("interrupt source missed");
   word_pair_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      half_mode_i && !pu_q && strobe_rise && half_pointer_o
      && !chip_select_n_i && !write_strobe_n_i
      |=> bus_word_valid_o
      && bus_word_o == {$past(bus_data_i[`WORD_W-`HALF_W-1:0]), low_half_q})
      else $error("half words not paired");
   flag_clear_a: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      pu_q |=> !interrupt_flag_o && !error_flag_o)
      else $error("flags not cleared by reset");
endmodule // tdc_reset_timer_flag_control
`default_nettype wire
